// *** design/atw_pkg.sv ***
// shared constants and types for the sector-write task-file link
package atw_pkg;
    // task-file register addresses on the link
    localparam logic [3:0]  TF_DATA             = 4'h0;
    localparam logic [3:0]  TF_FEATURE          = 4'h1;  // error_report on read
    localparam logic [3:0]  TF_COUNT            = 4'h2;
    localparam logic [3:0]  TF_LOW              = 4'h3;
    localparam logic [3:0]  TF_MID              = 4'h4;
    localparam logic [3:0]  TF_HIGH             = 4'h5;
    localparam logic [3:0]  TF_DRIVE            = 4'h6;
    localparam logic [3:0]  TF_OPCODE           = 4'h7;  // drive_condition on read
    // accepted opcodes
    localparam logic [7:0]  OP_WRITE            = 8'h30;
    localparam logic [7:0]  OP_WRITE_RETRY      = 8'h31;
    localparam logic [7:0]  OP_WRITE_EXT        = 8'h34;
    localparam logic [7:0]  OP_WRITE_VERIFY     = 8'h3C;
    // drive_condition and error_report bit positions
    localparam int          ST_BUSY             = 7;
    localparam int          ST_READY            = 6;
    localparam int          ST_SEEK_DONE        = 4;
    localparam int          ST_XFER_REQ         = 3;
    localparam int          ST_ERROR            = 0;
    localparam int          ER_ID_NOT_FOUND     = 4;
    localparam int          ER_COMMAND_ABORTED  = 2;
    localparam int          DRIVE_LBA_MODE      = 6;
    // reset values and counts
    localparam logic [7:0]  DRIVE_RESET         = 8'hA0;
    localparam logic [7:0]  WORD_LAST           = 8'hFF;     // 256 words per sector
    localparam logic [16:0] COUNT_28_ZERO       = 17'h00100; // zero count means 256
    localparam logic [16:0] COUNT_48_ZERO       = 17'h10000; // zero count means 65536
    localparam logic [7:0]  GEOM_SECTORS        = 8'h3F;     // sectors per track
    localparam logic [3:0]  GEOM_HEAD_LAST      = 4'hF;
    // timing at 25 MHz
    localparam int          CLK_KHZ             = 25000;
    localparam int          BUSY_AFTER_SECTOR_US = 5;
    localparam int          BUSY_AFTER_SECTOR_CYC = BUSY_AFTER_SECTOR_US * CLK_KHZ / 1000;
    localparam int          XFER_REQ_LIMIT_US   = 700;
    localparam int          XFER_REQ_LIMIT_CYC  = XFER_REQ_LIMIT_US * CLK_KHZ / 1000;
    // controller AHB register offsets
    localparam logic [7:0]  HR_TF_WRITE         = 8'h00;
    localparam logic [7:0]  HR_TF_READ          = 8'h04;
    localparam logic [7:0]  HR_READ_DATA        = 8'h08;
    localparam logic [7:0]  HR_IRQ_STATUS       = 8'h0C;
    localparam logic [7:0]  HR_IRQ_ENABLE       = 8'h10;
    localparam logic [7:0]  HR_IRQ_CLEAR        = 8'h14;
    localparam int          IRQ_DEVICE          = 0;
    localparam int          IRQ_READ_DONE       = 1;

    // task file with current and previous bytes
    typedef struct packed {
        logic [7:0] feat;
        logic [7:0] feat_p;
        logic [7:0] cnt;
        logic [7:0] cnt_p;
        logic [7:0] low;
        logic [7:0] low_p;
        logic [7:0] mid;
        logic [7:0] mid_p;
        logic [7:0] high;
        logic [7:0] high_p;
        logic [7:0] drive;
    } atw_taskfile_t;
endpackage

// *** design/atw_tf_if.sv ***
// task-file link between controller and drive
`timescale 1ns/1ps
`default_nettype none
interface atw_tf_if (
    input wire logic hclk
);
    logic [3:0]  addr;
    logic        high_order_byte_select;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        intrq;

    modport dev (input addr, input high_order_byte_select, input wdata, input wr, input rd, output rdata, output intrq);
    modport host (output addr, output high_order_byte_select, output wdata, output wr, output rd, input rdata, input intrq);
endinterface
`default_nettype wire

// *** design/atw_drive.sv ***
// drive end: task file, sector write commands, media hand-off
//
// Summary of operation
// - sector data arrives as 16-bit data words
// - 28-bit count zero means 256 sectors
// - geometry mode: sector, cylinder, head fields
// - block mode: 28-bit address from four registers
// - completion count holds sectors not transferred
// - completion address is last transferred sector
// - uncorrectable error stops write at failing sector; with auto_reassign_on set the write goes on
// - opcode 34h extended; registers keep previous byte
// - extended count 16 bits; zero means 65536
// - 48-bit address from current and previous bytes
// - extended error reports failing address, select byte
// - opcode 3Ch behaves exactly like 30h
// - interrupt after each sector
// - busy set soon after 256th data word
// - busy clears, request rises within 700 us
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atw_drive
    import atw_pkg::*;
#(
    parameter int COMMIT_LIMIT_CYC = XFER_REQ_LIMIT_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    atw_tf_if.dev            tf,
    output logic [15:0]      media_word,
    output logic             media_word_valid,
    output logic [47:0]      media_lba,
    output logic             media_commit,
    input  wire logic        media_commit_ack,
    input  wire logic        media_fail,
    input  wire logic        auto_reassign_on
);
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_XFER, S_COMMIT} atw_state_t;

    atw_state_t    state,      next_state;
    atw_taskfile_t tfr,        next_tfr;
    logic [7:0]    err_rep,    next_err_rep;
    logic          busy,       next_busy;
    logic          xfer_req,   next_xfer_req;
    logic          err_flag,   next_err_flag;
    logic          intrq,      next_intrq;
    logic          ext,        next_ext;
    logic [16:0]   remaining,  next_remaining;
    logic [7:0]    word_cnt,   next_word_cnt;
    logic [15:0]   timer,      next_timer;
    logic [15:0]   rdata,      next_rdata;
    logic [15:0]   mword,      next_mword;
    logic          mvalid,     next_mvalid;
    logic          commit,     next_commit;
    logic [7:0]    status;

    // step the address one sector in the active layout
    function automatic atw_taskfile_t advance(atw_taskfile_t t, logic e);
        logic [47:0] a;
        logic [15:0] cyl;
        a   = 48'h0;
        cyl = 16'h0;
        if (e) begin
            a = {t.high_p, t.mid_p, t.low_p, t.high, t.mid, t.low} + 48'h1;
            {t.high_p, t.mid_p, t.low_p, t.high, t.mid, t.low} = a;
        end else if (t.drive[DRIVE_LBA_MODE]) begin
            a = {20'h0, t.drive[3:0], t.high, t.mid, t.low} + 48'h1;
            {t.drive[3:0], t.high, t.mid, t.low} = a[27:0];
        end else if (t.low < GEOM_SECTORS) begin
            t.low = t.low + 8'h01;
        end else begin
            t.low = 8'h01;
            if (t.drive[3:0] < GEOM_HEAD_LAST) begin
                t.drive[3:0] = t.drive[3:0] + 4'h1;
            end else begin
                t.drive[3:0] = 4'h0;
                cyl = {t.high, t.mid} + 16'h0001;
                {t.high, t.mid} = cyl;
            end
        end
        return t;
    endfunction

    // media-facing address of the current sector
    function automatic logic [47:0] addr_of(atw_taskfile_t t, logic e);
        if (e) begin
            addr_of = {t.high_p, t.mid_p, t.low_p, t.high, t.mid, t.low};
        end else begin
            addr_of = {20'h0, t.drive[3:0], t.high, t.mid, t.low};
        end
    endfunction

    assign status = {busy, 1'b1, 1'b0, 1'b1, xfer_req, 1'b0, 1'b0, err_flag};

    // command decode, data intake and completion
    always_comb begin
        next_state     = state;
        next_tfr       = tfr;
        next_err_rep   = err_rep;
        next_busy      = busy;
        next_xfer_req  = xfer_req;
        next_err_flag  = err_flag;
        next_intrq     = intrq;
        next_ext       = ext;
        next_remaining = remaining;
        next_word_cnt  = word_cnt;
        next_timer     = 16'h0;
        next_rdata     = rdata;
        next_mword     = mword;
        next_mvalid    = 1'b0;
        next_commit    = commit;
        // register reads; the hob select picks previous bytes
        if (tf.rd) begin
            case (tf.addr)
                TF_FEATURE: next_rdata = {8'h00, err_rep};
                TF_COUNT:   next_rdata = {8'h00, tf.high_order_byte_select ? tfr.cnt_p  : tfr.cnt};
                TF_LOW:     next_rdata = {8'h00, tf.high_order_byte_select ? tfr.low_p  : tfr.low};
                TF_MID:     next_rdata = {8'h00, tf.high_order_byte_select ? tfr.mid_p  : tfr.mid};
                TF_HIGH:    next_rdata = {8'h00, tf.high_order_byte_select ? tfr.high_p : tfr.high};
                TF_DRIVE:   next_rdata = {8'h00, tfr.drive};
                TF_OPCODE:  next_rdata = {8'h00, status};
                default:    next_rdata = 16'h0000;
            endcase
            if (tf.addr == TF_OPCODE) begin
                next_intrq = 1'b0;   // status read acknowledges
            end
        end
        case (state)
            S_IDLE: begin
                if (tf.wr) begin
                    // each feature, count or address byte write pushes the old byte to previous
                    case (tf.addr)
                        TF_FEATURE: {next_tfr.feat_p, next_tfr.feat} = {tfr.feat, tf.wdata[7:0]};
                        TF_COUNT:   {next_tfr.cnt_p, next_tfr.cnt}   = {tfr.cnt, tf.wdata[7:0]};
                        TF_LOW:     {next_tfr.low_p, next_tfr.low}   = {tfr.low, tf.wdata[7:0]};
                        TF_MID:     {next_tfr.mid_p, next_tfr.mid}   = {tfr.mid, tf.wdata[7:0]};
                        TF_HIGH:    {next_tfr.high_p, next_tfr.high} = {tfr.high, tf.wdata[7:0]};
                        TF_DRIVE:   next_tfr.drive = tf.wdata[7:0];
                        TF_OPCODE: begin
                            next_intrq     = 1'b0;
                            next_err_rep   = 8'h00;
                            next_err_flag  = 1'b0;
                            next_word_cnt  = 8'h00;
                            next_busy      = 1'b1;
                            next_state     = S_SETUP;
                            case (tf.wdata[7:0])
                                // the low opcode bit only marks retry
                                OP_WRITE, OP_WRITE_RETRY, OP_WRITE_VERIFY: begin
                                    next_ext       = 1'b0;
                                    next_remaining = (tfr.cnt == 8'h00) ? COUNT_28_ZERO
                                                                        : {9'h000, tfr.cnt};
                                end
                                OP_WRITE_EXT: begin
                                    next_ext       = 1'b1;
                                    next_remaining = ({tfr.cnt_p, tfr.cnt} == 16'h0000) ? COUNT_48_ZERO
                                                                        : {1'b0, tfr.cnt_p, tfr.cnt};
                                end
                                default: begin
                                    // unknown opcode: abort at once
                                    next_busy      = 1'b0;
                                    next_state     = S_IDLE;
                                    next_err_flag  = 1'b1;
                                    next_err_rep   = 8'h01 << ER_COMMAND_ABORTED;
                                    next_intrq     = 1'b1;
                                end
                            endcase
                        end
                        default: ;
                    endcase
                end
            end
            S_SETUP: begin
                // first sector asks for data with no interrupt
                next_busy     = 1'b0;
                next_xfer_req = 1'b1;
                next_state    = S_XFER;
            end
            S_XFER: begin
                if (tf.wr && tf.addr == TF_DATA) begin
                    next_mword    = tf.wdata;
                    next_mvalid   = 1'b1;
                    next_word_cnt = word_cnt + 8'h01;
                    if (word_cnt == WORD_LAST) begin
                        // busy on the very next edge, far inside 5 us
                        next_busy     = 1'b1;
                        next_xfer_req = 1'b0;
                        next_commit   = 1'b1;
                        next_state    = S_COMMIT;
                    end
                end
            end
            S_COMMIT: begin
                next_timer = timer + 16'h0001;
                if (media_commit_ack || timer == 16'(COMMIT_LIMIT_CYC - 1)) begin
                    next_commit = 1'b0;
                    next_busy   = 1'b0;
                    next_intrq  = 1'b1;
                    next_state  = S_IDLE;
                    if (!media_commit_ack || (media_fail && !auto_reassign_on)) begin
                        // stop here; address stays on the failing sector
                        next_err_flag = 1'b1;
                        next_err_rep  = media_commit_ack ? (8'h01 << ER_ID_NOT_FOUND)
                                                         : (8'h01 << ER_COMMAND_ABORTED);
                        {next_tfr.cnt_p, next_tfr.cnt} = remaining[15:0];
                    end else if (remaining == 17'h00001) begin
                        // address left on the last transferred sector
                        {next_tfr.cnt_p, next_tfr.cnt} = 16'h0000;
                        next_remaining = 17'h00000;
                    end else begin
                        next_remaining = remaining - 17'h00001;
                        next_tfr       = advance(tfr, ext);
                        next_xfer_req  = 1'b1;
                        next_state     = S_XFER;
                    end
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= S_IDLE;
            tfr       <= '0;
            err_rep   <= 8'h00;
            busy      <= 1'b0;
            xfer_req  <= 1'b0;
            err_flag  <= 1'b0;
            intrq     <= 1'b0;
            ext       <= 1'b0;
            remaining <= 17'h00000;
            word_cnt  <= 8'h00;
            timer     <= 16'h0000;
            rdata     <= 16'h0000;
            mword     <= 16'h0000;
            mvalid    <= 1'b0;
            commit    <= 1'b0;
            tfr.drive <= DRIVE_RESET;
        end else begin
            state     <= next_state;
            tfr       <= next_tfr;
            err_rep   <= next_err_rep;
            busy      <= next_busy;
            xfer_req  <= next_xfer_req;
            err_flag  <= next_err_flag;
            intrq     <= next_intrq;
            ext       <= next_ext;
            remaining <= next_remaining;
            word_cnt  <= next_word_cnt;
            timer     <= next_timer;
            rdata     <= next_rdata;
            mword     <= next_mword;
            mvalid    <= next_mvalid;
            commit    <= next_commit;
        end
    end

    assign tf.rdata       = rdata;
    assign tf.intrq       = intrq;
    assign media_word       = mword;
    assign media_word_valid = mvalid;
    assign media_commit     = commit;
    assign media_lba        = addr_of(tfr, ext);
endmodule
`default_nettype wire

// *** design/atw_host.sv ***
// controller end: AHB-Lite registers driving the task-file link
`timescale 1ns/1ps
`default_nettype none
module atw_host
    import atw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    atw_tf_if.host           tf
);
    logic        ph_valid,   next_ph_valid;
    logic        ph_write,   next_ph_write;
    logic [7:0]  ph_addr,    next_ph_addr;
    logic [3:0]  l_addr,     next_l_addr;
    logic        l_hob,      next_l_hob;
    logic [15:0] l_wdata,    next_l_wdata;
    logic        l_wr,       next_l_wr;
    logic        l_rd,       next_l_rd;
    logic        l_wait,     next_l_wait;
    logic [15:0] rd_data,    next_rd_data;
    logic [1:0]  irq_status, next_irq_status;
    logic [1:0]  irq_enable, next_irq_enable;
    logic        intrq_d,    next_intrq_d;
    logic [31:0] rdata_q,    next_rdata_q;
    logic        irq_q,      next_irq_q;
    logic [1:0]  irq_clr;
    logic [1:0]  irq_set;

    // stall new transfers until a link access has landed
    assign hreadyout = !(l_wr || l_rd || l_wait);
    assign hresp     = 1'b0;

    // AHB decode, link strobes, interrupt bookkeeping
    always_comb begin
        next_ph_valid   = ph_valid;
        next_ph_write   = ph_write;
        next_ph_addr    = ph_addr;
        next_l_addr     = l_addr;
        next_l_hob      = l_hob;
        next_l_wdata    = l_wdata;
        next_l_wr       = 1'b0;
        next_l_rd       = 1'b0;
        next_l_wait     = l_rd;          // device answers one edge after the strobe
        next_rd_data    = rd_data;
        next_irq_enable = irq_enable;
        next_intrq_d    = tf.intrq;
        next_rdata_q    = rdata_q;
        irq_clr         = 2'b00;
        if (hready) begin
            next_ph_valid = hsel && htrans[1] && hsize == 3'b010;
            next_ph_write = hwrite;
            next_ph_addr  = haddr;
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr)
                    HR_READ_DATA:  next_rdata_q = {16'h0000, rd_data};
                    HR_IRQ_STATUS: next_rdata_q = {30'h0, irq_status};
                    HR_IRQ_ENABLE: next_rdata_q = {30'h0, irq_enable};
                    default:       next_rdata_q = 32'h00000000;
                endcase
            end
        end
        if (ph_valid && ph_write) begin
            case (ph_addr)
                HR_TF_WRITE: begin
                    // one 16-bit word or byte per link write
                    next_l_wr    = 1'b1;
                    next_l_addr  = hwdata[19:16];
                    next_l_wdata = hwdata[15:0];
                    next_l_hob   = 1'b0;
                end
                HR_TF_READ: begin
                    next_l_rd   = 1'b1;
                    next_l_addr = hwdata[19:16];
                    next_l_hob  = hwdata[20];
                end
                HR_IRQ_ENABLE: next_irq_enable = hwdata[1:0];
                HR_IRQ_CLEAR:  irq_clr = hwdata[1:0];
                default: ;
            endcase
        end
        if (l_wait) begin
            next_rd_data = tf.rdata;
        end
        // a new event outranks a clear in the same cycle
        irq_set         = {l_wait, tf.intrq && !intrq_d};
        next_irq_status = (irq_status & ~irq_clr) | irq_set;
        next_irq_q      = |(next_irq_status & next_irq_enable);
    end

    // state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid   <= 1'b0;
            ph_write   <= 1'b0;
            ph_addr    <= 8'h00;
            l_addr     <= 4'h0;
            l_hob      <= 1'b0;
            l_wdata    <= 16'h0000;
            l_wr       <= 1'b0;
            l_rd       <= 1'b0;
            l_wait     <= 1'b0;
            rd_data    <= 16'h0000;
            irq_status <= 2'b00;
            irq_enable <= 2'b00;
            intrq_d    <= 1'b0;
            rdata_q    <= 32'h00000000;
            irq_q      <= 1'b0;
        end else begin
            ph_valid   <= next_ph_valid;
            ph_write   <= next_ph_write;
            ph_addr    <= next_ph_addr;
            l_addr     <= next_l_addr;
            l_hob      <= next_l_hob;
            l_wdata    <= next_l_wdata;
            l_wr       <= next_l_wr;
            l_rd       <= next_l_rd;
            l_wait     <= next_l_wait;
            rd_data    <= next_rd_data;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            intrq_d    <= next_intrq_d;
            rdata_q    <= next_rdata_q;
            irq_q      <= next_irq_q;
        end
    end

    assign hrdata   = rdata_q;
    assign irq      = irq_q;
    assign tf.addr  = l_addr;
    assign tf.high_order_byte_select   = l_hob;
    assign tf.wdata = l_wdata;
    assign tf.wr    = l_wr;
    assign tf.rd    = l_rd;
endmodule
`default_nettype wire

// *** tb/atw_link_asserts.sv ***
// link checker for the sector-write task-file link
`timescale 1ns/1ps
`default_nettype none
module atw_link_asserts
    import atw_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [3:0]  addr,
    input wire logic        high_order_byte_select,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        intrq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // status reads and interrupt clearing causes
    wire st_rd = rd && addr == TF_OPCODE;
    wire clr   = st_rd || (wr && addr == TF_OPCODE);
    AST_STROBES: assert property (wr |-> !rd ##1 !wr) else $error("link strobes overlap");
    AST_RD_PULSE: assert property (rd |=> !rd) else $error("read strobe too long");
    AST_READY: assert property (st_rd |=> rdata[ST_READY] && rdata[ST_SEEK_DONE]) else $error("ready low");
    AST_NO_COR: assert property (st_rd |=> !rdata[2] && !rdata[5]) else $error("corrected set");
    AST_BUSY_REQ: assert property (st_rd |=> !(rdata[ST_BUSY] && rdata[ST_XFER_REQ])) else $error("busy with req");
    AST_ERR_BITS: assert property (rd && addr == TF_FEATURE |=> (rdata[7:0] & 8'hEB) == 8'h00) else $error("bad error bits");
    AST_INTRQ_FALL: assert property ($fell(intrq) |-> $past(clr)) else $error("intrq dropped alone");
    AST_FIRST_QUIET: assert property (wr && addr == TF_OPCODE && wdata[7:0] == OP_WRITE |=> !intrq [*2]) else $error("early intrq");
    // main scenarios reached
    cover property (st_rd && intrq);
    cover property (wr && addr == TF_OPCODE);
    cover property (rd && high_order_byte_select);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for both ends of the sector-write link
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import atw_pkg::*;
;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, irq, ack, fl, auto, mvalid, commit;
    logic [1:0]  htrans;
    logic [7:0]  haddr;
    logic [31:0] hwdata, hrdata;
    logic [15:0] mword, last_w;
    logic [47:0] mlba, last_a;
    int          fails = 0, n_tests = 0;
    atw_tf_if tf (.hclk(hclk));
    atw_host i_atw_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .tf(tf.host));
    atw_drive #(.COMMIT_LIMIT_CYC(50)) i_atw_drive (.hclk(hclk), .hresetn(hresetn), .tf(tf.dev),
        .media_word(mword), .media_word_valid(mvalid), .media_lba(mlba), .media_commit(commit),
        .media_commit_ack(ack), .media_fail(fl), .auto_reassign_on(auto));
    atw_link_asserts i_atw_link_asserts (.hclk(hclk), .hresetn(hresetn), .addr(tf.addr), .high_order_byte_select(tf.high_order_byte_select),
        .wdata(tf.wdata), .wr(tf.wr), .rd(tf.rd), .rdata(tf.rdata), .intrq(tf.intrq));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // media answers each commit one cycle later; keep what it saw
    always @(posedge hclk) begin
        ack <= commit && !ack;
        if (mvalid) last_w <= mword;
        if (commit) last_a <= mlba;
    end
    task automatic results();
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // expected status or error byte built from its bit positions
    function automatic logic [47:0] bit_pair(input int b1, input int b2);
        return (48'h1 << b1) | (48'h1 << b2);
    endfunction
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // sample at the falling edge, where hreadyout and hrdata are settled
    task automatic wt(output logic [31:0] r);
        logic y;
        int   k;
        k = 0;
        do begin
            @(negedge hclk);
            y = hreadyout;
            r = hrdata;
            k++;
            @(posedge hclk);
        end while (y !== 1'b1 && k < 200);
        if (k >= 200) begin
            fails++;
            results();
        end
    endtask
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wt(r);
        htrans <= 2'h0;
        hwdata <= d;
        wt(r);
    endtask
    task automatic tf_wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] r;
        ahb(HR_TF_WRITE, 1'b1, {12'h0, a, d}, r);
    endtask
    task automatic tf_rd(input logic [3:0] a, input logic h, output logic [47:0] v);
        logic [31:0] r;
        ahb(HR_TF_READ, 1'b1, {11'h0, h, a, 16'h0}, r);
        ahb(HR_READ_DATA, 1'b0, 32'h0, r);
        v = 48'(r[7:0]);
    endtask
    // status polling is bounded; a stuck drive ends the run
    task automatic poll(input int b, input logic x);
        logic [47:0] s;
        int          k;
        k = 0;
        do begin
            tf_rd(TF_OPCODE, 1'b0, s);
            k++;
        end while (s[b] !== x && k < 60);
        if (k >= 60) begin
            fails++;
            results();
        end
    endtask
    // previous bytes first, then current; 28-bit commands ignore the former
    task automatic cmd(input logic [7:0] op, input logic [7:0] drv, input logic [47:0] a, input int n, input int fa);
        logic [15:0] w;
        tf_wr(TF_COUNT, {8'h0, 8'(n >> 8)});
        tf_wr(TF_COUNT, {8'h0, 8'(n)});
        for (int k = 0; k < 3; k++) begin
            tf_wr(TF_LOW + 4'(k), {8'h0, a[24 + 8 * k +: 8]});
            tf_wr(TF_LOW + 4'(k), {8'h0, a[8 * k +: 8]});
        end
        tf_wr(TF_DRIVE, {8'h0, drv});
        tf_wr(TF_OPCODE, {8'h0, op});
        poll(ST_XFER_REQ, 1'b1);
        for (int s = 0; s < n; s++) begin
            fl <= (s == fa);
            for (int j = 0; j < 256; j++) begin
                w = 16'($urandom);
                tf_wr(TF_DATA, w);
            end
            poll(ST_BUSY, 1'b0);
            chk(48'(last_w), 48'(w));
            chk(last_a, a + 48'(s));
            if (s == fa && !auto) break;
        end
        fl <= 1'b0;
    endtask
    initial begin
        logic [47:0] v, a, b;
        logic [31:0] r;
        logic [7:0]  op [4];
        {hwrite, htrans, haddr, hwdata, fl, auto, hresetn} = '0;
        op = '{OP_WRITE, OP_WRITE_RETRY, OP_WRITE_VERIFY, OP_WRITE_EXT};
        void'($urandom(32'hd896));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        tf_rd(TF_OPCODE, 1'b0, v);
        chk(v, bit_pair(ST_READY, ST_SEEK_DONE));
        ahb(HR_IRQ_ENABLE, 1'b1, 32'h1, r);
        auto <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = {8'($urandom), 32'($urandom), 8'(1 + $urandom % 62)};
            if (i < 3) a[47:28] = '0;
            cmd(op[i], (i == 3) ? 8'h40 : {1'b1, 1'(i), 2'b10, a[27:24]}, a, 2, 1);
            tf_rd(TF_COUNT, 1'b0, v);
            chk(v, 48'h0);
            tf_rd(TF_LOW, 1'b0, v);
            chk(v, 48'(a[7:0] + 8'h1));
            tf_rd(TF_OPCODE, 1'b0, v);
            chk(v, bit_pair(ST_READY, ST_SEEK_DONE));
        end
        chk(48'(irq), 48'h1);
        // clear with the enable still set, so only the clear can drop irq
        ahb(HR_IRQ_CLEAR, 1'b1, 32'h1, r);
        @(negedge hclk);
        chk(48'({irq, hresp}), 48'h0);
        @(posedge hclk);
        ahb(HR_IRQ_ENABLE, 1'b1, 32'h1, r);
        ahb(HR_IRQ_STATUS, 1'b0, 32'h0, r);
        chk(48'({irq, r[0]}), 48'h0);
        ahb(8'h3C, 1'b0, 32'h0, r);
        chk(48'(r), 48'h0);
        auto <= 1'b0;
        b = a + 48'h1;
        cmd(OP_WRITE_EXT, 8'h40, a, 3, 1);
        tf_rd(TF_COUNT, 1'b0, v);
        chk(v, 48'h2);
        tf_rd(TF_LOW, 1'b1, v);
        chk(v, 48'(b[31:24]));
        tf_rd(TF_FEATURE, 1'b0, v);
        chk(v, bit_pair(ER_ID_NOT_FOUND, ER_ID_NOT_FOUND));
        tf_wr(TF_OPCODE, 16'h0099);
        tf_rd(TF_FEATURE, 1'b0, v);
        chk(v, bit_pair(ER_COMMAND_ABORTED, ER_COMMAND_ABORTED));
        results();
    end
endmodule
`default_nettype wire
